// ---- core/vpf_pkg.sv ----
package vpf_pkg;
  localparam logic [3:0] ADR_STATUS = 4'h2;
  localparam logic [3:0] ADR_AUDIO_CTRL = 4'ha;
  localparam logic [3:0] ADR_SPEED = 4'hb;
  localparam logic [3:0] ADR_ROLE_A = 4'hc;
  localparam logic [3:0] ADR_ROLE_B = 4'hd;
  localparam logic [3:0] ADR_IRQ_STAT = 4'he;
  localparam logic [3:0] ADR_IRQ_MASK = 4'hf;
  localparam logic [3:0] ROLE_A_RST = 4'h0;
  localparam logic [3:0] ROLE_B_RST = 4'h0;
  localparam logic [3:0] AUDIO_CTRL_RST = 4'h0;
  localparam logic [3:0] SPEED_RST = 4'h0;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam int RA_OFFTRACK_BIT = 0;
  localparam int RA_LEVEL_MODE_BIT = 1;
  localparam int RA_LEVEL_BIT = 2;
  localparam int AC_FLAG_EMBED_BIT = 3;
  localparam int SP_DOUBLE_BIT = 0;
  localparam int ST_INPUT_A_BIT = 0;
  localparam int ST_INPUT_B_BIT = 1;
  localparam int ST_TSYNC_BIT = 2;
  localparam int IRQ_FRAME_BIT = 0;
  localparam int IRQ_C1_FAIL_BIT = 1;
  localparam int IRQ_C2_FAIL_BIT = 2;
  localparam logic [1:0] ERR_UNCORRECTABLE = 2'h3;
  localparam int FLAG_BITS = 7;
  localparam int SUBFRAME_FLAG_BIT = 4;
  localparam int CLK_HZ = 50000000;
  localparam int FRAME_HZ = 7350;
  localparam int BIT_CYCLES = CLK_HZ / (FRAME_HZ * 8);
  localparam logic [9:0] BIT_CNT_MAX = 10'(BIT_CYCLES - 1);
endpackage

// ---- core/vpf_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module vpf_top (
  input wire logic i_clk, // 50 MHz
  input wire logic i_reset_n, // Sync reset
  input wire logic [3:0] i_wb_adr, // Word address
  input wire logic [31:0] i_wb_dat, // Write data
  output logic [31:0] o_wb_dat, // Read data
  input wire logic i_wb_we, // Write
  input wire logic [3:0] i_wb_sel, // Byte lanes
  input wire logic i_wb_cyc, // Cycle
  input wire logic i_wb_stb, // Strobe
  output logic o_wb_ack, // Ack
  output logic o_irq, // Level interrupt
  input wire logic i_offtrack_or_gp_input, // Pin one
  input wire logic i_general_input_b, // Pin two
  output logic o_offtrack, // Off-track to servo
  input wire logic i_right_silence_200ms, // Right silence held 200 ms
  input wire logic i_subcode_qw, // Q-to-W subcode
  input wire logic i_deemph, // De-emphasis active
  input wire logic i_motor_c, // Extra motor line 1
  input wire logic i_motor_d, // Extra motor line 2
  input wire logic i_fifo_subcode_sync, // Subcode sync after FIFO
  input wire logic i_frame_strobe, // Frame start, one cycle
  input wire logic [1:0] i_first_correction_stage, // C1 result
  input wire logic [1:0] i_second_correction_stage, // C2 result
  input wire logic i_conceal_hold, // Hold seen
  input wire logic i_conceal_interp, // Interpolation seen
  input wire logic i_subframe_bit4, // Audio subframe bit 4 in
  output logic o_subframe_bit4, // Audio subframe bit 4 out
  output logic o_right_kill_or_level_out, // Pin three output
  output logic o_right_kill_or_level_out_oe, // Pin three drive enable
  output logic o_subcode_or_motor_out_a, // Pin four
  output logic o_deemph_or_motor_out_b, // Pin five
  output logic o_error_flag_serial_out, // Flag pin output level
  output logic o_error_flag_serial_out_oe, // Flag pin drive enable
  output logic o_double_speed // Double speed select
);
  logic [3:0] role_a_ff, nxt_role_a;
  logic [3:0] role_b_ff, nxt_role_b;
  logic [3:0] audio_ctrl_ff, nxt_audio_ctrl;
  logic [3:0] speed_ff, nxt_speed;
  logic [2:0] irq_stat_ff, nxt_irq_stat;
  logic [2:0] irq_mask_ff, nxt_irq_mask;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [6:0] word_ff, nxt_word;
  logic [6:0] shift_ff, nxt_shift;
  logic [2:0] bit_idx_ff, nxt_bit_idx;
  logic [9:0] bit_cnt_ff, nxt_bit_cnt;
  logic tsync_ff, nxt_tsync;
  logic flag_ff, nxt_flag;
  logic req;
  logic wr;
  logic [2:0] events;

  assign req = i_wb_cyc && i_wb_stb && !ack_ff;
  assign wr = req && i_wb_we && i_wb_sel[0];

  always_comb
  begin
    events = '0;
    events[vpf_pkg::IRQ_FRAME_BIT] = i_frame_strobe;
    events[vpf_pkg::IRQ_C1_FAIL_BIT] = i_frame_strobe
      && (i_first_correction_stage == vpf_pkg::ERR_UNCORRECTABLE);
    events[vpf_pkg::IRQ_C2_FAIL_BIT] = i_frame_strobe
      && (i_second_correction_stage == vpf_pkg::ERR_UNCORRECTABLE);
  end

  // Register file and bus answer
  always_comb
  begin
    nxt_role_a = role_a_ff;
    nxt_role_b = role_b_ff;
    nxt_audio_ctrl = audio_ctrl_ff;
    nxt_speed = speed_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_ack = req;
    nxt_rdat = '0;
    if (wr)
    begin
      unique case (i_wb_adr)
        vpf_pkg::ADR_ROLE_A: nxt_role_a = i_wb_dat[3:0];
        vpf_pkg::ADR_ROLE_B: nxt_role_b = i_wb_dat[3:0];
        vpf_pkg::ADR_AUDIO_CTRL: nxt_audio_ctrl = i_wb_dat[3:0];
        vpf_pkg::ADR_SPEED: nxt_speed = i_wb_dat[3:0];
        vpf_pkg::ADR_IRQ_MASK: nxt_irq_mask = i_wb_dat[2:0];
        default: nxt_irq_mask = irq_mask_ff;
      endcase
    end
    if (req && !i_wb_we)
    begin
      unique case (i_wb_adr)
        vpf_pkg::ADR_STATUS:
        begin
          nxt_rdat[vpf_pkg::ST_INPUT_A_BIT] = i_offtrack_or_gp_input;
          nxt_rdat[vpf_pkg::ST_INPUT_B_BIT] = i_general_input_b;
          nxt_rdat[vpf_pkg::ST_TSYNC_BIT] = tsync_ff;
        end
        vpf_pkg::ADR_AUDIO_CTRL: nxt_rdat[3:0] = audio_ctrl_ff;
        vpf_pkg::ADR_SPEED: nxt_rdat[3:0] = speed_ff;
        vpf_pkg::ADR_IRQ_STAT:
        begin
          nxt_rdat[2:0] = irq_stat_ff;
          nxt_irq_stat = '0;
        end
        vpf_pkg::ADR_IRQ_MASK: nxt_rdat[2:0] = irq_mask_ff;
        default: nxt_rdat = '0;
      endcase
    end
    // Set wins over read-clear
    nxt_irq_stat = nxt_irq_stat | events;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      role_a_ff <= vpf_pkg::ROLE_A_RST;
      role_b_ff <= vpf_pkg::ROLE_B_RST;
      audio_ctrl_ff <= vpf_pkg::AUDIO_CTRL_RST;
      speed_ff <= vpf_pkg::SPEED_RST;
      irq_stat_ff <= vpf_pkg::IRQ_RST;
      irq_mask_ff <= vpf_pkg::IRQ_RST;
      ack_ff <= 1'b0;
      rdat_ff <= '0;
    end
    else
    begin
      role_a_ff <= nxt_role_a;
      role_b_ff <= nxt_role_b;
      audio_ctrl_ff <= nxt_audio_ctrl;
      speed_ff <= nxt_speed;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // Flag word capture and serialiser
  always_comb
  begin
    nxt_word = word_ff;
    nxt_shift = shift_ff;
    nxt_bit_idx = bit_idx_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_tsync = i_fifo_subcode_sync ? 1'b1 : (i_frame_strobe ? 1'b0 : tsync_ff);
    nxt_flag = flag_ff;
    if (i_frame_strobe)
    begin
      nxt_word = {i_fifo_subcode_sync | tsync_ff,
                  i_first_correction_stage,
                  i_second_correction_stage,
                  i_conceal_hold, i_conceal_interp};
      nxt_shift = nxt_word;
      nxt_bit_idx = 3'h0;
      nxt_bit_cnt = '0;
      nxt_flag = nxt_word[vpf_pkg::FLAG_BITS - 1];
    end
    else if (bit_cnt_ff == vpf_pkg::BIT_CNT_MAX)
    begin
      nxt_bit_cnt = '0;
      if (bit_idx_ff != 3'(vpf_pkg::FLAG_BITS - 1))
      begin
        nxt_bit_idx = bit_idx_ff + 3'h1;
        nxt_shift = {shift_ff[5:0], 1'b0};
        nxt_flag = shift_ff[5];
      end
      else
      begin
        nxt_flag = 1'b1;
      end
    end
    else
    begin
      nxt_bit_cnt = bit_cnt_ff + 10'h1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      word_ff <= '0;
      shift_ff <= '0;
      // Start idle on the last bit so the pin stays released until the first strobe
      bit_idx_ff <= 3'(vpf_pkg::FLAG_BITS - 1);
      bit_cnt_ff <= '0;
      tsync_ff <= 1'b0;
      flag_ff <= 1'b1;
    end
    else
    begin
      word_ff <= nxt_word;
      shift_ff <= nxt_shift;
      bit_idx_ff <= nxt_bit_idx;
      bit_cnt_ff <= nxt_bit_cnt;
      tsync_ff <= nxt_tsync;
      flag_ff <= nxt_flag;
    end
  end

  // Pin roles
  always_comb
  begin
    o_offtrack = role_a_ff[vpf_pkg::RA_OFFTRACK_BIT] & i_offtrack_or_gp_input;
    if (!role_a_ff[vpf_pkg::RA_LEVEL_MODE_BIT])
    begin
      o_right_kill_or_level_out = 1'b0;
      o_right_kill_or_level_out_oe = i_right_silence_200ms;
    end
    else
    begin
      o_right_kill_or_level_out = role_a_ff[vpf_pkg::RA_LEVEL_BIT];
      o_right_kill_or_level_out_oe = !role_a_ff[vpf_pkg::RA_LEVEL_BIT];
    end
    if (role_b_ff == 4'h0)
    begin
      o_subcode_or_motor_out_a = i_motor_c;
      o_deemph_or_motor_out_b = i_motor_d;
    end
    else
    begin
      unique case (role_b_ff[1:0])
        2'h1: o_subcode_or_motor_out_a = i_subcode_qw;
        2'h2: o_subcode_or_motor_out_a = 1'b0;
        2'h3: o_subcode_or_motor_out_a = 1'b1;
        default: o_subcode_or_motor_out_a = 1'b0;
      endcase
      unique case (role_b_ff[3:2])
        2'h1: o_deemph_or_motor_out_b = i_deemph;
        2'h2: o_deemph_or_motor_out_b = 1'b0;
        2'h3: o_deemph_or_motor_out_b = 1'b1;
        default: o_deemph_or_motor_out_b = 1'b0;
      endcase
    end
  end

  assign o_error_flag_serial_out = 1'b0;
  assign o_error_flag_serial_out_oe = !flag_ff;
  assign o_subframe_bit4 = audio_ctrl_ff[vpf_pkg::AC_FLAG_EMBED_BIT] ? flag_ff
    : i_subframe_bit4;
  assign o_double_speed = speed_ff[vpf_pkg::SP_DOUBLE_BIT];
  assign o_irq = |(irq_stat_ff & irq_mask_ff);
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;
endmodule
`default_nettype wire

// ---- sim/vpf_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module vpf_assertions (
  input wire logic i_clk, // Clock
  input wire logic i_reset_n, // Reset
  input wire logic [3:0] i_wb_adr, // Address
  input wire logic [31:0] i_wb_dat, // Data
  input wire logic i_wb_we, // Write
  input wire logic [3:0] i_wb_sel, // Lanes
  input wire logic i_wb_cyc, // Cycle
  input wire logic i_wb_stb, // Strobe
  input wire logic o_wb_ack, // Ack
  input wire logic i_offtrack_or_gp_input, // Pin one
  input wire logic o_offtrack, // Servo
  input wire logic i_right_silence_200ms, // Silence
  input wire logic o_right_kill_or_level_out_oe, // Pin three
  input wire logic i_motor_c, // Motor
  input wire logic i_subcode_qw, // Subcode
  input wire logic o_subcode_or_motor_out_a, // Pin four
  input wire logic i_fifo_subcode_sync, // Sync
  input wire logic i_frame_strobe, // Frame
  input wire logic o_error_flag_serial_out, // Flag level
  input wire logic o_error_flag_serial_out_oe, // Flag drive
  input wire logic o_double_speed // Speed
);
  logic wr;
  logic [3:0] ra_ff, rb_ff;
  logic sp_ff, ts_ff;
  // Shadow registers follow writes at the acknowledging edge
  assign wr = o_wb_ack && i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0];
  always_ff @(posedge i_clk)
  begin
    ra_ff <= !i_reset_n ? 4'h0 : (wr && i_wb_adr == 4'hc) ? i_wb_dat[3:0] : ra_ff;
    rb_ff <= !i_reset_n ? 4'h0 : (wr && i_wb_adr == 4'hd) ? i_wb_dat[3:0] : rb_ff;
    sp_ff <= !i_reset_n ? 1'b0 : (wr && i_wb_adr == 4'hb) ? i_wb_dat[0] : sp_ff;
    ts_ff <= !i_reset_n ? 1'b0 : i_fifo_subcode_sync ? 1'b1 : i_frame_strobe ? 1'b0 : ts_ff;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_ack_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  a_ack_one_pulse: assert property (s_req |=> s_ack_pulse) else $error("ack not one pulse");
  a_offtrack_route: assert property (!o_wb_ack |-> o_offtrack == (ra_ff[0] & i_offtrack_or_gp_input))
    else $error("offtrack route wrong");
  a_kill_mode: assert property (!o_wb_ack && !ra_ff[1] |-> o_right_kill_or_level_out_oe == i_right_silence_200ms)
    else $error("kill output wrong");
  a_level_mode: assert property (!o_wb_ack && ra_ff[1] |-> o_right_kill_or_level_out_oe == !ra_ff[2])
    else $error("pin three level wrong");
  a_motor_route: assert property (!o_wb_ack && rb_ff == 4'h0 |-> o_subcode_or_motor_out_a == i_motor_c)
    else $error("motor route wrong");
  a_subcode_route: assert property (!o_wb_ack && rb_ff[1:0] == 2'h1 |-> o_subcode_or_motor_out_a == i_subcode_qw)
    else $error("subcode route wrong");
  a_speed_select: assert property (!o_wb_ack |-> o_double_speed == sp_ff) else $error("speed wrong");
  a_flag_first: assert property (i_frame_strobe |=> o_error_flag_serial_out_oe != $past(ts_ff | i_fifo_subcode_sync))
    else $error("first flag bit wrong");
  a_flag_bit_hold: assert property (i_frame_strobe |=> ##1 $stable(o_error_flag_serial_out_oe)[*8])
    else $error("flag bit not held");
  a_flag_open_drain: assert property (!o_error_flag_serial_out) else $error("flag drives high");
endmodule
bind vpf_top vpf_assertions u_chk (.i_clk, .i_reset_n, .i_wb_adr, .i_wb_dat, .i_wb_we, .i_wb_sel,
  .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_offtrack_or_gp_input, .o_offtrack, .i_right_silence_200ms,
  .o_right_kill_or_level_out_oe, .i_motor_c, .i_subcode_qw, .o_subcode_or_motor_out_a,
  .i_fifo_subcode_sync, .i_frame_strobe, .o_error_flag_serial_out, .o_error_flag_serial_out_oe,
  .o_double_speed);
`default_nettype wire

// ---- sim/vpf_far_side.sv ----
`timescale 1ns/100ps
`default_nettype none
module vpf_far_side (
  input wire logic i_flag_oe, // Flag drive
  input wire logic i_flag_lvl, // Flag level
  input wire logic i_pin3_oe, // Pin three drive
  input wire logic i_pin3_lvl, // Pin three level
  output logic o_flag_line, // Flag wire
  output logic o_pin3_line // Pin three wire
);
  // Both wires carry pull-ups on the board
  assign o_flag_line = i_flag_oe ? i_flag_lvl : 1'b1;
  assign o_pin3_line = i_pin3_oe ? i_pin3_lvl : 1'b1;
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic i_clk, i_reset_n, i_wb_we, i_wb_cyc, i_wb_stb, o_wb_ack, o_irq, i_offtrack_or_gp_input;
  logic [3:0] i_wb_adr, i_wb_sel, v;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  logic [1:0] i_first_correction_stage, i_second_correction_stage;
  logic i_general_input_b, o_offtrack, i_right_silence_200ms, i_subcode_qw, i_deemph, i_motor_c;
  logic i_motor_d, i_fifo_subcode_sync, i_frame_strobe, i_conceal_hold, i_conceal_interp;
  logic i_subframe_bit4, o_subframe_bit4, o_right_kill_or_level_out, o_right_kill_or_level_out_oe;
  logic o_subcode_or_motor_out_a, o_deemph_or_motor_out_b, o_error_flag_serial_out;
  logic o_error_flag_serial_out_oe, o_double_speed, fline, p3line;
  int err_count, samples_checked;
  localparam logic [6:0] WORD = 7'b1110110;
  localparam logic [3:0] RB [6] = '{4'h0, 4'h5, 4'ha, 4'hf, 4'h6, 4'h9};
  vpf_top u_vpf_top (.i_clk, .i_reset_n, .i_wb_adr, .i_wb_dat, .o_wb_dat, .i_wb_we, .i_wb_sel,
    .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_irq, .i_offtrack_or_gp_input, .i_general_input_b,
    .o_offtrack, .i_right_silence_200ms, .i_subcode_qw, .i_deemph, .i_motor_c, .i_motor_d,
    .i_fifo_subcode_sync, .i_frame_strobe, .i_first_correction_stage, .i_second_correction_stage,
    .i_conceal_hold, .i_conceal_interp, .i_subframe_bit4, .o_subframe_bit4,
    .o_right_kill_or_level_out, .o_right_kill_or_level_out_oe, .o_subcode_or_motor_out_a,
    .o_deemph_or_motor_out_b, .o_error_flag_serial_out, .o_error_flag_serial_out_oe,
    .o_double_speed);
  vpf_far_side u_far (.i_flag_oe(o_error_flag_serial_out_oe), .i_flag_lvl(o_error_flag_serial_out),
    .i_pin3_oe(o_right_kill_or_level_out_oe), .i_pin3_lvl(o_right_kill_or_level_out),
    .o_flag_line(fline), .o_pin3_line(p3line));
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic close_out();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_wb_adr <= a;
    i_wb_we <= w;
    i_wb_dat <= d;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    do @(posedge i_clk); while (o_wb_ack !== 1'b1 && ++n < 20);
    if (n >= 20) err_count++;
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  initial
  begin
    {i_wb_we, i_wb_cyc, i_wb_stb, i_wb_adr, i_wb_dat, i_reset_n, i_general_input_b} = '0;
    {i_offtrack_or_gp_input, i_right_silence_200ms, i_deemph, i_subframe_bit4} = 4'h9;
    {i_subcode_qw, i_motor_c, i_motor_d, i_fifo_subcode_sync, i_frame_strobe} = 5'h08;
    {i_first_correction_stage, i_second_correction_stage, i_conceal_hold, i_conceal_interp} = '0;
    i_wb_sel = 4'hf;
    settle(5);
    i_reset_n <= 1'b1;
    wb(vpf_pkg::ADR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h1);
    i_general_input_b <= 1'b1;
    wb(vpf_pkg::ADR_ROLE_A, 1'b1, 32'h1);
    settle(2);
    chk(o_offtrack, 1'b1);
    wb(vpf_pkg::ADR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h3);
    wb(4'h5, 1'b1, 32'hf);
    wb(4'h5, 1'b0, 32'h0);
    chk(rd, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      i_right_silence_200ms <= (k != 3);
      wb(vpf_pkg::ADR_ROLE_A, 1'b1, {29'h0, k == 2, k == 1 || k == 2, 1'b0});
      settle(2);
      chk(p3line, k >= 2);
    end
    chk(o_offtrack, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      v = RB[k];
      wb(vpf_pkg::ADR_ROLE_B, 1'b1, {28'h0, v});
      settle(2);
      chk({o_subcode_or_motor_out_a, o_deemph_or_motor_out_b},
        {v == 0 ? i_motor_c : v[1:0] == 1 ? i_subcode_qw : v[0],
        v == 0 ? i_motor_d : v[3:2] == 1 ? i_deemph : v[2]});
    end
    wb(vpf_pkg::ADR_AUDIO_CTRL, 1'b1, 32'h8);
    wb(vpf_pkg::ADR_SPEED, 1'b1, 32'h1);
    wb(vpf_pkg::ADR_IRQ_MASK, 1'b1, 32'h2);
    settle(2);
    chk(o_double_speed, 1'b1);
    i_fifo_subcode_sync <= 1'b1;
    settle(1);
    {i_fifo_subcode_sync, i_first_correction_stage, i_second_correction_stage} <= 5'h0d;
    {i_frame_strobe, i_conceal_hold} <= 2'h3;
    settle(1);
    i_frame_strobe <= 1'b0;
    settle(vpf_pkg::BIT_CYCLES / 2);
    for (int k = 6; k >= 0; k--)
    begin
      chk({fline, o_subframe_bit4}, {2{WORD[k]}});
      settle(vpf_pkg::BIT_CYCLES);
    end
    chk({fline, o_irq}, 2'h3);
    wb(vpf_pkg::ADR_IRQ_STAT, 1'b0, 32'h0);
    chk(rd, 32'h3);
    settle(2);
    chk(o_irq, 1'b0);
    close_out();
  end
  initial
  begin
    #(20 * 20000);
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
